/* core/fspc_pkg.sv */
// fspc_pkg: constants and carrier types for the flash self-program controller
// assumes a wishbone classic slave with 32-bit data, one register per word
package fspc_pkg;
    localparam logic [7:0] FSPC_OFS_DATA = 8'h00;
    localparam logic [7:0] FSPC_OFS_ADRH = 8'h04;
    localparam logic [7:0] FSPC_OFS_ADRL = 8'h08;
    localparam logic [7:0] FSPC_OFS_MODE = 8'h0c;
    localparam logic [7:0] FSPC_OFS_CMD = 8'h10;
    localparam logic [7:0] FSPC_OFS_CTRL = 8'h14;
    localparam logic [7:0] FSPC_OFS_LOWB = 8'h18;
    localparam logic [7:0] FSPC_OFS_STAT = 8'h1c;
    localparam logic [7:0] FSPC_RST_DATA = 8'hff;
    localparam logic [7:0] FSPC_RST_LOWB = 8'h76;
    localparam logic [7:0] FSPC_KEY1 = 8'h46;
    localparam logic [7:0] FSPC_KEY2 = 8'hb9;
    localparam logic [2:0] FSPC_SW_APP = 3'h1;
    localparam logic [2:0] FSPC_SW_LDR2APP = 3'h5;
    localparam logic [2:0] FSPC_SW_APP2LDR = 3'h7;
    localparam logic [15:0] FSPC_TOP_NOLDR = 16'h7fff;
    localparam int FSPC_CTRL_EN = 7;
    localparam int FSPC_CTRL_FAIL = 4;
    localparam int FSPC_PAGE_BITS = 9;
    localparam int FSPC_CLK_MHZ = 125;
    localparam int FSPC_PROG_US = 30;
    localparam int FSPC_ERASE_US = 5;
    localparam int FSPC_PROG_CYC = FSPC_PROG_US * FSPC_CLK_MHZ;
    localparam int FSPC_ERASE_CYC = FSPC_ERASE_US * FSPC_CLK_MHZ;
    localparam int FSPC_READ_CYC = 2;

    typedef enum logic [1:0] {
        FSPC_M_IDLE = 2'b00,
        FSPC_M_READ = 2'b01,
        FSPC_M_PROG = 2'b10,
        FSPC_M_ERASE = 2'b11
    } fspc_mode_t;

    typedef enum logic [1:0] {
        FSPC_S_IDLE = 2'b00,
        FSPC_S_BUSY = 2'b01,
        FSPC_S_DONE = 2'b10
    } fspc_state_t;

    // flash array request
    typedef struct packed {
        logic rd;
        logic wr;
        logic erase;
        logic [15:0] addr;
        logic [7:0] wdata;
    } fspc_flash_req_t;

    // boot decision handed to the reset controller
    typedef struct packed {
        logic req;
        logic toLoader;
    } fspc_boot_t;
endpackage

/* core/fspc_ctrl.sv */
// fspc_ctrl: flash self-program sequencer with wishbone register slave
// assumes the flash array answers reads within FSPC_READ_CYC; cpu honours cpuStall
module fspc_ctrl #(
    parameter int PROG_CYC = fspc_pkg::FSPC_PROG_CYC,
    parameter int ERASE_CYC = fspc_pkg::FSPC_ERASE_CYC,
    parameter logic [15:0] LOADER_START = 16'h7a00,
    parameter bit LOADER_EN = 1'b1
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic runInLoader,
    input wire logic powerOnReset,
    input wire logic extReset,
    input wire logic bootFromLoaderOption,
    input wire logic loaderBootOnExtResetOption,
    input wire logic [15:0] fetchAddr,
    output logic [15:0] fetchPhysAddr,
    input wire logic [7:0] flashRdata,
    output fspc_pkg::fspc_flash_req_t flashReq,
    output logic cpuStall,
    input wire logic [3:0] intPending,
    output logic [3:0] intService,
    output fspc_pkg::fspc_boot_t bootReq,
    output logic bootVector
);
    logic [7:0] dataPort_r, adrH_r, adrL_r, mode_r, lowBound_r;
    logic progEnable_r, bootSel_r, cmdFail_r, armed_r;
    fspc_pkg::fspc_state_t state_r;
    logic [31:0] cnt_r;
    logic [31:0] rdMux;
    logic wbHit, wbWr, start, allowed, launch;
    logic [15:0] target, upperBound, lowerBound;
    logic strap_r;

    function automatic logic inRange(input logic [15:0] a, input logic [15:0] lo,
                                     input logic [15:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    assign wbHit = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wbWr = wbHit && wb_we_i && wb_sel_i[0];
    assign target = {adrH_r, adrL_r};

    // data region bounds
    always_comb begin
        if (LOADER_EN) begin
            upperBound = LOADER_START - 16'h0001;
        end else begin
            upperBound = fspc_pkg::FSPC_TOP_NOLDR;
        end
        lowerBound = {lowBound_r, 8'h00};
    end

    always_comb begin
        if (runInLoader) begin
            allowed = target <= upperBound;
        end else begin
            allowed = inRange(target, lowerBound, upperBound);
        end
    end

    // two-byte unlock; start requires enable
    assign start = wbWr && wb_adr_i == fspc_pkg::FSPC_OFS_CMD && armed_r
        && wb_dat_i[7:0] == fspc_pkg::FSPC_KEY2 && progEnable_r
        && state_r == fspc_pkg::FSPC_S_IDLE;

    // start that reaches the flash: legal mode and permitted address
    assign launch = start && allowed && mode_r[7:2] == 6'h00
        && mode_r[1:0] != 2'b00;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            armed_r <= 1'b0;
        end else if (wbWr && wb_adr_i == fspc_pkg::FSPC_OFS_CMD) begin
            armed_r <= wb_dat_i[7:0] == fspc_pkg::FSPC_KEY1;
        end
    end

    // sequencer
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_r <= fspc_pkg::FSPC_S_IDLE;
            cnt_r <= 32'h0;
            flashReq <= '0;
            cpuStall <= 1'b0;
        end else begin
            case (state_r)
                fspc_pkg::FSPC_S_IDLE: begin
                    flashReq <= '0;
                    if (launch) begin
                        state_r <= fspc_pkg::FSPC_S_BUSY;
                        cpuStall <= 1'b1;
                        flashReq.rd <= mode_r[1:0] == fspc_pkg::FSPC_M_READ;
                        flashReq.wr <= mode_r[1:0] == fspc_pkg::FSPC_M_PROG;
                        flashReq.erase <= mode_r[1:0] == fspc_pkg::FSPC_M_ERASE;
                        if (mode_r[1:0] == fspc_pkg::FSPC_M_ERASE) begin
                            flashReq.addr <= {target[15:fspc_pkg::FSPC_PAGE_BITS],
                                9'h000};
                            cnt_r <= 32'(ERASE_CYC);
                        end else begin
                            flashReq.addr <= target;
                            cnt_r <= (mode_r[1:0] == fspc_pkg::FSPC_M_READ)
                                ? 32'(fspc_pkg::FSPC_READ_CYC) : 32'(PROG_CYC);
                        end
                        flashReq.wdata <= dataPort_r;
                    end
                end
                fspc_pkg::FSPC_S_BUSY: begin
                    if (cnt_r <= 32'h1) begin
                        state_r <= fspc_pkg::FSPC_S_DONE;
                    end else begin
                        cnt_r <= cnt_r - 32'h1;
                    end
                end
                fspc_pkg::FSPC_S_DONE: begin
                    flashReq <= '0;
                    cpuStall <= 1'b0;
                    state_r <= fspc_pkg::FSPC_S_IDLE;
                end
                default: state_r <= fspc_pkg::FSPC_S_IDLE;
            endcase
        end
    end

    // interrupts held while stalled
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            intService <= 4'h0;
        end else begin
            // masked from the launch edge on, so no request slips out as the stall begins
            intService <= (cpuStall || launch) ? 4'h0 : intPending;
        end
    end

    // registers
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            dataPort_r <= fspc_pkg::FSPC_RST_DATA;
            adrH_r <= 8'h00;
            adrL_r <= 8'h00;
            mode_r <= 8'h00;
            lowBound_r <= fspc_pkg::FSPC_RST_LOWB;
            progEnable_r <= 1'b0;
            bootSel_r <= 1'b0;
        end else begin
            if (state_r == fspc_pkg::FSPC_S_DONE && flashReq.rd) begin
                dataPort_r <= flashRdata;
            end else if (wbWr && wb_adr_i == fspc_pkg::FSPC_OFS_DATA) begin
                dataPort_r <= wb_dat_i[7:0];
            end
            if (wbWr && wb_adr_i == fspc_pkg::FSPC_OFS_ADRH) adrH_r <= wb_dat_i[7:0];
            if (wbWr && wb_adr_i == fspc_pkg::FSPC_OFS_ADRL) adrL_r <= wb_dat_i[7:0];
            if (wbWr && wb_adr_i == fspc_pkg::FSPC_OFS_MODE) mode_r <= wb_dat_i[7:0];
            if (wbWr && wb_adr_i == fspc_pkg::FSPC_OFS_LOWB) begin
                lowBound_r <= wb_dat_i[7:0];
            end
            if (wbWr && wb_adr_i == fspc_pkg::FSPC_OFS_CTRL) begin
                progEnable_r <= wb_dat_i[fspc_pkg::FSPC_CTRL_EN];
                bootSel_r <= wb_dat_i[6];
            end
        end
    end

    // fail flag: hardware result wins over software write
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cmdFail_r <= 1'b0;
        end else if (start) begin
            cmdFail_r <= !allowed;
        end else if (wbWr && wb_adr_i == fspc_pkg::FSPC_OFS_CTRL) begin
            cmdFail_r <= wb_dat_i[fspc_pkg::FSPC_CTRL_FAIL];
        end
    end

    // soft reset and boot selection
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            bootReq <= '0;
        end else begin
            bootReq.req <= 1'b0;
            if (wbWr && wb_adr_i == fspc_pkg::FSPC_OFS_CTRL) begin
                case (wb_dat_i[7:5])
                    fspc_pkg::FSPC_SW_APP, fspc_pkg::FSPC_SW_LDR2APP: begin
                        bootReq.req <= 1'b1;
                        bootReq.toLoader <= 1'b0;
                    end
                    fspc_pkg::FSPC_SW_APP2LDR: begin
                        bootReq.req <= LOADER_EN;
                        bootReq.toLoader <= 1'b1;
                    end
                    default: bootReq.req <= 1'b0;
                endcase
            end
        end
    end

    // hardware boot straps sampled every cycle after reset release
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            strap_r <= 1'b0;
        end else begin
            strap_r <= LOADER_EN && bootFromLoaderOption
                && (powerOnReset || (extReset && loaderBootOnExtResetOption));
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            bootVector <= 1'b0;
        end else begin
            bootVector <= strap_r || bootSel_r;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            fetchPhysAddr <= 16'h0;
        end else begin
            fetchPhysAddr <= runInLoader ? fetchAddr + LOADER_START : fetchAddr;
        end
    end

    always_comb begin
        case (wb_adr_i)
            fspc_pkg::FSPC_OFS_DATA: rdMux = {24'h0, dataPort_r};
            fspc_pkg::FSPC_OFS_ADRH: rdMux = {24'h0, adrH_r};
            fspc_pkg::FSPC_OFS_ADRL: rdMux = {24'h0, adrL_r};
            fspc_pkg::FSPC_OFS_MODE: rdMux = {24'h0, mode_r};
            fspc_pkg::FSPC_OFS_CTRL: rdMux = {24'h0, progEnable_r, bootSel_r, 1'b0,
                cmdFail_r, 4'h0};
            fspc_pkg::FSPC_OFS_LOWB: rdMux = {24'h0, lowBound_r};
            fspc_pkg::FSPC_OFS_STAT: rdMux = {30'h0, state_r};
            default: rdMux = 32'h0;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wbHit;
            wb_dat_o <= wbHit ? rdMux : 32'h0;
        end
    end

    property p_stall_on_start;
        @(posedge clk_sys) disable iff (!rst_n)
        (start && allowed && mode_r == 8'h01) |=> cpuStall && flashReq.rd;
    endproperty
    a_stall_on_start: assert property (p_stall_on_start) else $error("no stall");

    property p_no_start_disabled;
        @(posedge clk_sys) disable iff (!rst_n)
        (!progEnable_r && state_r == fspc_pkg::FSPC_S_IDLE) |=> !cpuStall;
    endproperty
    a_no_start_disabled: assert property (p_no_start_disabled) else $error("start w/o en");

    property p_int_held;
        @(posedge clk_sys) disable iff (!rst_n)
        cpuStall |=> intService == 4'h0;
    endproperty
    a_int_held: assert property (p_int_held) else $error("int during stall");

    property p_int_masked;
        @(posedge clk_sys) disable iff (!rst_n)
        cpuStall |-> intService == 4'h0;
    endproperty
    a_int_masked: assert property (p_int_masked) else $error("int while stalled");

    property p_erase_align;
        @(posedge clk_sys) disable iff (!rst_n)
        flashReq.erase |-> flashReq.addr[8:0] == 9'h0;
    endproperty
    a_erase_align: assert property (p_erase_align) else $error("erase unaligned");

    property p_fail_set;
        @(posedge clk_sys) disable iff (!rst_n)
        (start && !allowed) |=> cmdFail_r && !cpuStall;
    endproperty
    a_fail_set: assert property (p_fail_set) else $error("fail flag");

    property p_read_data;
        @(posedge clk_sys) disable iff (!rst_n)
        (state_r == fspc_pkg::FSPC_S_DONE && flashReq.rd) |=> dataPort_r == $past(flashRdata);
    endproperty
    a_read_data: assert property (p_read_data) else $error("read data");

    property p_sw_reset;
        @(posedge clk_sys) disable iff (!rst_n)
        (wbWr && wb_adr_i == fspc_pkg::FSPC_OFS_CTRL && wb_dat_i[7:5] == 3'h1)
            |=> bootReq.req && !bootReq.toLoader;
    endproperty
    a_sw_reset: assert property (p_sw_reset) else $error("soft reset");

    property p_reserved;
        @(posedge clk_sys) disable iff (!rst_n)
        (start && mode_r == 8'h00) |=> !cpuStall;
    endproperty
    a_reserved: assert property (p_reserved) else $error("standby start");
endmodule // fspc_ctrl

/* tb/fspc_flash_model.sv */
// fspc_flash_model: behavioural on-chip flash array facing the sequencer
// assumes one request at a time, held steady by the sequencer while it runs
module fspc_flash_model (
    input wire logic clk_sys,
    input wire fspc_pkg::fspc_flash_req_t flashReq,
    output logic [7:0] flashRdata
);
    logic [7:0] mem [0:65535];
    logic wasBusy = 1'b0;

    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'hff;
        end
    end

    always @(posedge clk_sys) begin
        // released read bus toggles rather than holding the last byte
        if (flashReq.rd) begin
            flashRdata <= mem[flashReq.addr];
        end else begin
            flashRdata <= ~flashRdata;
        end
        if (flashReq.erase && !wasBusy) begin
            for (int i = 0; i < 512; i++) begin
                mem[{flashReq.addr[15:9], 9'(i)}] = 8'hff;
            end
        end
        // programming only clears bits
        if (flashReq.wr && !wasBusy) begin
            mem[flashReq.addr] = mem[flashReq.addr] & flashReq.wdata;
        end
        wasBusy <= flashReq.wr || flashReq.erase;
    end
endmodule // fspc_flash_model

/* tb/flash_self_program_ctrl_bench.sv */
// flash_self_program_ctrl_bench: self-checking bench for the flash self-program sequencer
// assumes fspc_ctrl with short program/erase counts and the flash model on its far side
module flash_self_program_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic wbCyc = 1'b0;
    logic wbStb = 1'b0;
    logic wbWe = 1'b0;
    logic [7:0] wbAdr = 8'h00;
    logic [3:0] wbSel = 4'h0;
    logic [31:0] wbDatW = 32'h0;
    logic [31:0] wbDatR;
    logic wbAck;
    logic runInLoader = 1'b0;
    logic powerOnReset = 1'b0;
    logic extReset = 1'b0;
    logic bootOpt = 1'b0;
    logic extOpt = 1'b0;
    logic [15:0] fetchAddr = 16'h0000;
    logic [15:0] fetchPhysAddr;
    logic [7:0] flashRdata;
    fspc_pkg::fspc_flash_req_t flashReq;
    logic cpuStall;
    logic [3:0] intPending = 4'h0;
    logic [3:0] intService;
    fspc_pkg::fspc_boot_t bootReq;
    fspc_pkg::fspc_boot_t bootSeen = '0;
    int bootCount = 0;
    logic bootVector;
    logic [3:0] svcDuring;
    int miscompares = 0;
    int comparisons = 0;

    fspc_ctrl #(.PROG_CYC(4), .ERASE_CYC(4), .LOADER_START(16'h7a00), .LOADER_EN(1'b1)) i_fspc_ctrl (
        .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
        .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR),
        .wb_ack_o(wbAck), .runInLoader(runInLoader), .powerOnReset(powerOnReset),
        .extReset(extReset), .bootFromLoaderOption(bootOpt), .loaderBootOnExtResetOption(extOpt),
        .fetchAddr(fetchAddr), .fetchPhysAddr(fetchPhysAddr), .flashRdata(flashRdata),
        .flashReq(flashReq), .cpuStall(cpuStall), .intPending(intPending),
        .intService(intService), .bootReq(bootReq), .bootVector(bootVector));
    fspc_flash_model i_fspc_flash_model (.clk_sys(clk_sys), .flashReq(flashReq),
        .flashRdata(flashRdata));

    always #4 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        if (bootReq.req) begin
            bootSeen <= bootReq;
            bootCount <= bootCount + 1;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d,
        output logic [31:0] q);
        @(posedge clk_sys);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= a;
        wbSel <= 4'hf;
        wbDatW <= {24'h0, d};
        do begin
            @(posedge clk_sys);
        end while (wbAck !== 1'b1);
        q = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        logic [31:0] q;
        wb(1'b0, a, 8'h00, q);
        v = q[7:0];
    endtask

    task automatic wait3;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask

    // set mode and address, unlock, then follow the stall to its end
    task automatic op(input logic [7:0] m, input logic [15:0] a, input logic exp);
        wr(fspc_pkg::FSPC_OFS_MODE, m);
        wr(fspc_pkg::FSPC_OFS_ADRH, a[15:8]);
        wr(fspc_pkg::FSPC_OFS_ADRL, a[7:0]);
        wr(fspc_pkg::FSPC_OFS_CMD, 8'h46);
        wr(fspc_pkg::FSPC_OFS_CMD, 8'hb9);
        #1;
        svcDuring = intService;
        check(cpuStall, exp);
        while (cpuStall !== 1'b0) begin
            @(posedge clk_sys);
        end
        @(posedge clk_sys);
        #1;
    endtask

    task automatic t_reset;
        logic [7:0] v;
        rd(fspc_pkg::FSPC_OFS_DATA, v);
        check(v, 8'hff);
        rd(fspc_pkg::FSPC_OFS_LOWB, v);
        check(v, 8'h76);
        rd(8'h20, v);
        check(v, 8'h00);
    endtask

    task automatic t_read;
        logic [7:0] v;
        i_fspc_flash_model.mem[16'h7610] = 8'h5a;
        wr(fspc_pkg::FSPC_OFS_CTRL, 8'h80);
        intPending <= 4'h5;
        op(8'h01, 16'h7610, 1'b1);
        check(svcDuring, 4'h0);
        rd(fspc_pkg::FSPC_OFS_DATA, v);
        check(v, 8'h5a);
        check(intService, 4'h5);
        intPending <= 4'h0;
        rd(fspc_pkg::FSPC_OFS_CTRL, v);
        check(v[4], 1'b0);
    endtask

    task automatic t_update;
        logic [7:0] v;
        op(8'h03, 16'h7600, 1'b1);
        check(i_fspc_flash_model.mem[16'h7610], 8'hff);
        wr(fspc_pkg::FSPC_OFS_DATA, 8'h3c);
        op(8'h02, 16'h7620, 1'b1);
        op(8'h01, 16'h7620, 1'b1);
        rd(fspc_pkg::FSPC_OFS_DATA, v);
        check(v, 8'h3c);
        op(8'h01, 16'h7621, 1'b1);
        rd(fspc_pkg::FSPC_OFS_DATA, v);
        check(v, 8'hff);
    endtask

    task automatic t_range;
        logic [7:0] v;
        wr(fspc_pkg::FSPC_OFS_DATA, 8'h00);
        op(8'h02, 16'h1000, 1'b0);
        rd(fspc_pkg::FSPC_OFS_CTRL, v);
        check(v[4], 1'b1);
        check(i_fspc_flash_model.mem[16'h1000], 8'hff);
        runInLoader <= 1'b1;
        op(8'h02, 16'h1000, 1'b1);
        check(i_fspc_flash_model.mem[16'h1000], 8'h00);
        op(8'h02, 16'h7a10, 1'b0);
        rd(fspc_pkg::FSPC_OFS_CTRL, v);
        check(v[4], 1'b1);
        runInLoader <= 1'b0;
        op(8'h02, 16'h75ff, 1'b0);
        wr(fspc_pkg::FSPC_OFS_LOWB, 8'h70);
        op(8'h02, 16'h7000, 1'b1);
        rd(fspc_pkg::FSPC_OFS_CTRL, v);
        check(v[4], 1'b0);
    endtask

    task automatic t_refuse;
        logic [7:0] v;
        logic [7:0] modes [3] = '{8'h00, 8'h05, 8'h13};
        wr(fspc_pkg::FSPC_OFS_CMD, 8'h46);
        wr(fspc_pkg::FSPC_OFS_CMD, 8'h00);
        wr(fspc_pkg::FSPC_OFS_CMD, 8'hb9);
        #1;
        check(cpuStall, 1'b0);
        wr(fspc_pkg::FSPC_OFS_CTRL, 8'h00);
        op(8'h01, 16'h7620, 1'b0);
        wr(fspc_pkg::FSPC_OFS_CTRL, 8'h80);
        for (int i = 0; i < 3; i++) begin
            op(modes[i], 16'h7620, 1'b0);
        end
        rd(fspc_pkg::FSPC_OFS_DATA, v);
        check(v, 8'h00);
    endtask

    task automatic t_fetch;
        runInLoader <= 1'b1;
        fetchAddr <= 16'h0010;
        wait3;
        check(fetchPhysAddr, 16'h7a10);
        @(posedge clk_sys);
        runInLoader <= 1'b0;
        wait3;
        check(fetchPhysAddr, 16'h0010);
    endtask

    task automatic t_boot;
        logic [7:0] codes [3] = '{8'h20, 8'ha0, 8'he0};
        logic toLoader [3] = '{1'b0, 1'b0, 1'b1};
        int n0;
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_sys);
            runInLoader <= (i == 1);
            n0 = bootCount;
            wr(fspc_pkg::FSPC_OFS_CTRL, codes[i]);
            wait3;
            check(bootCount - n0, 1);
            check(bootSeen, {1'b1, toLoader[i]});
        end
        check(bootVector, 1'b1);
        wr(fspc_pkg::FSPC_OFS_CTRL, 8'h00);
        wait3;
        check(bootVector, 1'b0);
        @(posedge clk_sys);
        powerOnReset <= 1'b1;
        bootOpt <= 1'b1;
        wait3;
        check(bootVector, 1'b1);
        @(posedge clk_sys);
        powerOnReset <= 1'b0;
        extReset <= 1'b1;
        wait3;
        check(bootVector, 1'b0);
        @(posedge clk_sys);
        extOpt <= 1'b1;
        wait3;
        check(bootVector, 1'b1);
    endtask

    task automatic stop_test;
        if (miscompares == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset;
        t_read;
        t_update;
        t_range;
        t_refuse;
        t_fetch;
        t_boot;
        stop_test;
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        stop_test;
    end
endmodule // flash_self_program_ctrl_bench
